/* File: fdtc_top.sv */
// drive timing, configuration and seek engine of the floppy controller
`default_nettype none
`include "fdtc_params.svh"
module fdtc_top #(
  parameter int UNIT_CYC_1M = `FDTC_UNIT_NS / `FDTC_CLK_NS
) (
  input  wire logic        clock,              // 250 MHz
  input  wire logic        rst_n,              // async reset, low
  input  wire logic [7:0]  addr,               // register byte address
  input  wire logic [31:0] wdata,              // write data
  input  wire logic        wr,                 // write strobe
  input  wire logic        rd,                 // read strobe
  output logic      [31:0] rdata,              // read data, next cycle
  input  wire logic        track_zero_input,   // drive at track 0, pin
  output logic             step_out,           // step pulse
  output logic             dir_out,            // 1 steps in
  output logic             head_load_out,      // head load
  input  wire logic        rw_request,         // read/write wanted
  input  wire logic [7:0]  rw_cylinder,        // its cylinder
  output logic             rw_start,           // read/write may begin
  input  wire logic        rw_done,            // read/write finished
  input  wire logic        xfer_need,          // data path wants a byte
  output logic             dma_request_out,    // DMA request
  output logic             request_for_master, // master request bit
  output logic             controller_interrupt, // interrupt
  output logic      [3:0]  fifo_burst,         // bytes per request - 1
  output logic             precomp_on          // precompensate this track
);
  // ****************************************************
  // timers
  // ****************************************************
  fdtc_pkg::fdtc_regs_t q;
  fdtc_pkg::fdtc_regs_t d;
  logic [2:0]  t_start;
  logic [2:0]  t_done;
  logic [2:0]  t_busy;
  logic [8:0]  t_units [3];
  logic [19:0] unit_lim;
  logic        trk0;
  logic        write_hit;
  logic [8:0]  hut_units;
  logic [8:0]  hlt_units;

  // unit is 0.5 ms at 1M; slower rates stretch it
  always_comb
  begin
    unique case (q.rate)
      fdtc_pkg::FDTC_R_2M:   unit_lim = 20'(UNIT_CYC_1M / 2 - 1);
      fdtc_pkg::FDTC_R_1M:   unit_lim = 20'(UNIT_CYC_1M - 1);
      fdtc_pkg::FDTC_R_500K: unit_lim = 20'(UNIT_CYC_1M * 2 - 1);
      fdtc_pkg::FDTC_R_300K: unit_lim = 20'(UNIT_CYC_1M * 10 / 3 - 1);
      fdtc_pkg::FDTC_R_250K: unit_lim = 20'(UNIT_CYC_1M * 4 - 1);
      default:               unit_lim = 20'(UNIT_CYC_1M * 2 - 1);
    endcase
  end

  assign t_units[0] = `FDTC_STEP_BASE - {5'h0, q.timing.step_interval};
  assign hut_units = (q.timing.head_unload_delay == 4'h0) ? `FDTC_LONG_UNITS
                                            : {1'b0, q.timing.head_unload_delay, 4'h0};
  assign hlt_units = (q.timing.head_load_delay == 7'h0) ? `FDTC_LONG_UNITS
                                            : {1'b0, q.timing.head_load_delay, 1'b0};
  assign t_units[1] = hlt_units;
  assign t_units[2] = hut_units;

  // 0 step interval, 1 head load, 2 head unload
  for (genvar i = 0; i < 3; i++)
  begin : g_tmr
    fdtc_delay u_dly (
      .clock    (clock),
      .rst_n    (rst_n),
      .start    (t_start[i]),
      .units    (t_units[i]),
      .unit_lim (unit_lim),
      .done     (t_done[i]),
      .busy     (t_busy[i])
    );
  end

  assign trk0      = q.trk_b;
  assign write_hit = wr;

  // ****************************************************
  // next state
  // ****************************************************
  always_comb
  begin
    d         = q;
    t_start   = 3'h0;
    d.step    = 1'b0;
    d.rw_go   = 1'b0;
    d.trk_a   = track_zero_input;
    d.trk_b   = q.trk_a;
    d.rdata   = 32'h0;

    if (write_hit && addr == `FDTC_A_TIMING)
      d.timing = fdtc_pkg::fdtc_timing_t'(wdata[15:0]);
    if (write_hit && addr == `FDTC_A_CONFIG)
      d.cfg = fdtc_pkg::fdtc_config_t'(wdata[15:0]);
    if (write_hit && addr == `FDTC_A_RATE)
      d.rate = fdtc_pkg::fdtc_rate_t'(wdata[2:0]);

    if (rd)
    begin
      unique case (addr)
        `FDTC_A_TIMING:   d.rdata = {16'h0, q.timing};
        `FDTC_A_CONFIG:   d.rdata = {16'h0, q.cfg};
        `FDTC_A_RATE:     d.rdata = {29'h0, q.rate};
        `FDTC_A_STATUS0:  d.rdata = {24'h0, q.ic, q.se, q.ec, 4'h0};
        `FDTC_A_POSITION: d.rdata = {22'h0, q.st != fdtc_pkg::FDTC_S_IDLE,
                                     q.loaded, q.present_cylinder};
        `FDTC_A_VERSION:  d.rdata = {24'h0, `FDTC_VERSION};
        default:          d.rdata = 32'h0;
      endcase
    end

    // status read acts as the sense; a new event below still wins
    if (rd && addr == `FDTC_A_STATUS0)
      d.irq = 1'b0;

    // unload only outside load and read/write, else a late expiry drops a busy head
    if (t_done[2] && q.st != fdtc_pkg::FDTC_S_LOAD
        && q.st != fdtc_pkg::FDTC_S_RW)
      d.loaded = 1'b0;

    // one poll interrupt after reset, held off while head is loaded
    if (q.poll_pend && !q.cfg.poll_dis && !q.loaded && !t_busy[2]
        && q.st == fdtc_pkg::FDTC_S_IDLE)
    begin
      d.poll_pend = 1'b0;
      d.irq       = 1'b1;
      d.ic        = 2'h3;
      d.se        = 1'b0;
      d.ec        = 1'b0;
    end

    if (xfer_need && q.timing.nodma)
      d.irq = 1'b1;

    unique case (q.st)
      fdtc_pkg::FDTC_S_IDLE:
      begin
        // a motion write while busy is dropped, so two never overlap
        if (write_hit && addr == `FDTC_A_MOTION)
        begin
          d.kind     = fdtc_pkg::fdtc_kind_t'(wdata[10:9]);
          d.rw_after = 1'b0;
          d.st       = fdtc_pkg::FDTC_S_PULSE;
          unique case (fdtc_pkg::fdtc_kind_t'(wdata[10:9]))
            fdtc_pkg::FDTC_K_REL:
            begin
              d.steps = wdata[7:0];
              d.dir   = wdata[8];
            end
            fdtc_pkg::FDTC_K_RECAL:
            begin
              d.present_cylinder   = 8'h0;
              d.steps = `FDTC_RECAL_MAX;
              d.dir   = 1'b0;
            end
            default:
            begin
              d.kind   = fdtc_pkg::FDTC_K_SEEK;
              d.target = wdata[7:0];
              d.dir    = (wdata[7:0] > q.present_cylinder);
            end
          endcase
        end
        else if (rw_request)
        begin
          if (q.cfg.implied_seek_enable && rw_cylinder != q.present_cylinder)
          begin
            d.kind     = fdtc_pkg::FDTC_K_SEEK;
            d.target   = rw_cylinder;
            d.dir      = (rw_cylinder > q.present_cylinder);
            d.rw_after = 1'b1;
            d.st       = fdtc_pkg::FDTC_S_PULSE;
          end
          else if (q.loaded)
          begin
            d.rw_go = 1'b1;
            d.st    = fdtc_pkg::FDTC_S_RW;
          end
          else
          begin
            t_start[1] = 1'b1;
            d.loaded   = 1'b1;
            d.st       = fdtc_pkg::FDTC_S_LOAD;
          end
        end
      end

      fdtc_pkg::FDTC_S_PULSE:
      begin
        // decide: finish (normal or abnormal) or give one more step
        if ((q.kind == fdtc_pkg::FDTC_K_REL && q.steps == 8'h0)
            || (q.kind == fdtc_pkg::FDTC_K_SEEK && q.present_cylinder == q.target)
            || (q.kind == fdtc_pkg::FDTC_K_RECAL && trk0))
        begin
          d.se  = 1'b1;
          d.ec  = 1'b0;
          d.ic  = 2'h0;
          d.irq = 1'b1;
        end
        else if ((q.kind == fdtc_pkg::FDTC_K_REL && !q.dir && trk0)
                 || (q.kind == fdtc_pkg::FDTC_K_RECAL && q.steps == 8'h0))
        begin
          d.se  = 1'b1;
          d.ec  = 1'b1;
          d.ic  = 2'h1;
          d.irq = 1'b1;
        end
        else
        begin
          d.step     = 1'b1;
          t_start[0] = 1'b1;
          d.steps    = q.steps - 8'h1;
          if (q.kind != fdtc_pkg::FDTC_K_RECAL)
            d.present_cylinder = q.dir ? q.present_cylinder + 8'h1 : q.present_cylinder - 8'h1;
        end
        if (!d.step)
        begin
          if (q.rw_after && !d.ec)
          begin
            d.st = q.loaded ? fdtc_pkg::FDTC_S_RW : fdtc_pkg::FDTC_S_LOAD;
            d.rw_go    = q.loaded;
            t_start[1] = !q.loaded;
            d.loaded   = 1'b1;
          end
          else
          begin
            d.st = fdtc_pkg::FDTC_S_IDLE;
          end
        end
        else
        begin
          d.st = fdtc_pkg::FDTC_S_GAP;
        end
      end

      // every gap is the full interval; the early second step is not used
      fdtc_pkg::FDTC_S_GAP:
      begin
        if (t_done[0])
          d.st = fdtc_pkg::FDTC_S_PULSE;
      end

      fdtc_pkg::FDTC_S_LOAD:
      begin
        if (t_done[1])
        begin
          d.rw_go = 1'b1;
          d.st    = fdtc_pkg::FDTC_S_RW;
        end
      end

      fdtc_pkg::FDTC_S_RW:
      begin
        if (rw_done)
        begin
          t_start[2] = 1'b1;
          d.st       = fdtc_pkg::FDTC_S_IDLE;
        end
      end

      default:
        d.st = fdtc_pkg::FDTC_S_IDLE;
    endcase
  end

  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q           <= '0;
      q.timing    <= `FDTC_TIMING_RST;
      q.cfg       <= `FDTC_CONFIG_RST;
      q.rate      <= fdtc_pkg::fdtc_rate_t'(`FDTC_RATE_RST);
      q.poll_pend <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign rdata                = q.rdata;
  assign step_out             = q.step;
  assign dir_out              = q.dir;
  assign head_load_out        = q.loaded;
  assign rw_start             = q.rw_go;
  assign controller_interrupt = q.irq;
  assign dma_request_out      = xfer_need && !q.timing.nodma;
  assign request_for_master   = xfer_need && q.timing.nodma;
  assign fifo_burst = q.cfg.fifo_dis ? 4'h0 : q.cfg.thr;
  assign precomp_on = (q.present_cylinder >= q.cfg.precomp_start_track);

  // ****************************************************
  // checks
  // ****************************************************
  logic [7:0] recal_n;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      recal_n <= 8'h0;
    else if (q.st == fdtc_pkg::FDTC_S_IDLE)
      recal_n <= 8'h0;
    else if (q.step && q.kind == fdtc_pkg::FDTC_K_RECAL)
      recal_n <= recal_n + 8'h1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_out_at_zero;
    q.st == fdtc_pkg::FDTC_S_PULSE && q.kind == fdtc_pkg::FDTC_K_REL
      && !q.dir && q.steps != 8'h0 && trk0;
  endsequence
  sequence s_ec_end;
    q.ec && q.se && !step_out ##1 q.st == fdtc_pkg::FDTC_S_IDLE;
  endsequence

  a_rel_out_ec: assert property (s_out_at_zero |=> s_ec_end)
    else $error("outward step past track zero not flagged");
  a_step_spacing: assert property (step_out |=> !step_out [*2])
    else $error("step pulses too close");
  a_rel_wrap: assert property (step_out && q.kind == fdtc_pkg::FDTC_K_REL
      |-> q.present_cylinder == 8'($past(q.present_cylinder) + (q.dir ? 8'h1 : 8'hff)))
    else $error("cylinder not stepped modulo 256");
  a_recal_limit: assert property (recal_n <= 8'h50)
    else $error("recalibrate gave more than 80 steps");
  a_dma_route: assert property (xfer_need && !q.timing.nodma
      |-> dma_request_out && !request_for_master)
    else $error("DMA transfer routed wrongly");
  a_pio_irq: assert property (xfer_need && q.timing.nodma
      |=> controller_interrupt)
    else $error("non-DMA transfer raised no interrupt");
  a_timing_load: assert property (wr && addr == `FDTC_A_TIMING
      |=> q.timing == $past(wdata[15:0]))
    else $error("timing fields not loaded together");
  a_load_first: assert property ($rose(rw_start)
      |-> head_load_out && $past(head_load_out))
    else $error("read/write began before head load");
  a_single_byte: assert property (q.cfg.fifo_dis && xfer_need
      |-> fifo_burst == 4'h0)
    else $error("burst with FIFO disabled");
endmodule
`default_nettype wire

/* File: fdtc_params.svh */
// constants of the floppy timing, configuration and relative seek block
// What this block does
// - timing write loads unload delay, step interval and load delay at once
// - unload delay runs from end of read/write to unloaded head
// - step interval code F is 0.5 ms, E 1 ms, 0 8 ms at 1M
// - every step, the second included, keeps the full interval
// - load delay runs from head load high to read/write start
// - all three delays scale with data rate, same for both densities
// - transfer-mode bit 1 selects non-DMA, 0 selects DMA
// - DMA mode uses DMA request; non-DMA uses master request and interrupt
// - without configuration the built-in defaults apply
// - implied seek set means seek before a read or write to another cylinder
// - FIFO disabled (default) means one byte per transfer request
// - polling enabled (default) gives one interrupt after reset
// - no polling while the head is loaded and unload delay runs
// - threshold 0 means one byte, F means sixteen bytes
// - precompensation starts at the programmed track, default track 0
// - version query returns one fixed byte, 5a, an arbitrary value that names no part
// - relative seek direction 0 steps out, 1 steps in
// - relative seek steps the count exactly; cylinder wraps modulo 256
// - only one relative seek at a time
// - relative seek outward past track zero sets equipment check
// - recalibrate gives at most 80 steps, error if track zero unseen
// - all other commands use the present cylinder counter
// - seek steps are spaced by the step interval
`ifndef FDTC_PARAMS_SVH
`define FDTC_PARAMS_SVH
`define FDTC_A_TIMING   8'h00
`define FDTC_A_CONFIG   8'h04
`define FDTC_A_RATE     8'h08
`define FDTC_A_MOTION   8'h0c
`define FDTC_A_STATUS0  8'h10
`define FDTC_A_POSITION 8'h14
`define FDTC_A_VERSION  8'h18
`define FDTC_TIMING_RST 16'h0000
`define FDTC_CONFIG_RST 16'h0002
`define FDTC_RATE_RST   3'h0
`define FDTC_CLK_NS     4
`define FDTC_UNIT_NS    500000
`define FDTC_STEP_BASE  9'h010
`define FDTC_LONG_UNITS 9'h100
`define FDTC_RECAL_MAX  8'h50
`define FDTC_VERSION    8'h5a // arbitrary value, names no part
`endif

/* File: fdtc_pkg.sv */
// types of the floppy timing, configuration and relative seek block
`default_nettype none
package fdtc_pkg;
  typedef enum logic [2:0]
  {
    FDTC_S_IDLE  = 3'h0,
    FDTC_S_PULSE = 3'h1,
    FDTC_S_GAP   = 3'h3,
    FDTC_S_LOAD  = 3'h2,
    FDTC_S_RW    = 3'h6
  } fdtc_state_t;
  typedef enum logic [1:0]
  {
    FDTC_K_SEEK  = 2'h0,
    FDTC_K_REL   = 2'h1,
    FDTC_K_RECAL = 2'h2
  } fdtc_kind_t;
  typedef enum logic [2:0]
  {
    FDTC_R_500K = 3'h0,
    FDTC_R_300K = 3'h1,
    FDTC_R_250K = 3'h2,
    FDTC_R_1M   = 3'h3,
    FDTC_R_2M   = 3'h4
  } fdtc_rate_t;
  typedef struct packed {
    logic       nodma;
    logic [6:0] head_load_delay;
    logic [3:0] head_unload_delay;
    logic [3:0] step_interval;
  } fdtc_timing_t;
  typedef struct packed {
    logic [7:0] precomp_start_track;
    logic [3:0] thr;
    logic       spare;
    logic       poll_dis;
    logic       fifo_dis;
    logic       implied_seek_enable;
  } fdtc_config_t;
  typedef struct packed {
    logic [19:0] pre;
    logic [8:0]  left;
    logic        done;
  } fdtc_dly_t;
  typedef struct packed {
    fdtc_timing_t timing;
    fdtc_config_t cfg;
    fdtc_rate_t   rate;
    fdtc_state_t  st;
    fdtc_kind_t   kind;
    logic [7:0]   present_cylinder;
    logic [7:0]   target;
    logic [7:0]   steps;
    logic         dir;
    logic         rw_after;
    logic [1:0]   ic;
    logic         se;
    logic         ec;
    logic         irq;
    logic         poll_pend;
    logic         loaded;
    logic         step;
    logic         rw_go;
    logic         trk_a;
    logic         trk_b;
    logic [31:0]  rdata;
  } fdtc_regs_t;
endpackage
`default_nettype wire

/* File: fdtc_delay.sv */
// one drive delay timer counting whole rate-scaled time units
`default_nettype none
module fdtc_delay (
  input  wire logic        clock,    // controller clock
  input  wire logic        rst_n,    // async reset, low
  input  wire logic        start,    // load units and run
  input  wire logic [8:0]  units,    // delay length in units
  input  wire logic [19:0] unit_lim, // cycles per unit minus one
  output logic             done,     // pulse after the delay
  output logic             busy      // delay running
);
  fdtc_pkg::fdtc_dly_t q;
  fdtc_pkg::fdtc_dly_t d;

  // own prescaler, so a restart never shortens the first unit
  always_comb
  begin
    d      = q;
    d.done = 1'b0;
    if (start)
    begin
      d.pre  = 20'h0;
      d.left = units;
    end
    else if (q.left != 9'h0)
    begin
      if (q.pre == unit_lim)
      begin
        d.pre  = 20'h0;
        d.left = q.left - 9'h1;
        d.done = (q.left == 9'h1);
      end
      else
      begin
        d.pre = q.pre + 20'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign done = q.done;
  assign busy = (q.left != 9'h0);
endmodule
`default_nettype wire

/* File: fdtc_drive_model.sv */
// behavioural drive mechanism: head position and track zero sensor
`default_nettype none
module fdtc_drive_model (
  input  wire logic       clock,            // controller clock
  input  wire logic       rst_n,            // async reset, low
  input  wire logic       step_out,         // step pulse
  input  wire logic       dir_out,          // 1 steps in
  input  wire logic       set_pos,          // place the head
  input  wire logic [8:0] new_pos,          // placement track
  output logic            track_zero_input, // head at track 0
  output logic      [8:0] pos               // physical track
);
  timeunit 1ns;
  timeprecision 100ps;
  // tracks past 255 exist on the medium, so nine bits of position
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pos <= 9'h000;
    else if (set_pos)
      pos <= new_pos;
    else if (step_out && dir_out)
      pos <= pos + 9'h001;
    else if (step_out && pos != 9'h000)
      pos <= pos - 9'h001;
  end
  // mechanical stop: stepping out at track 0 leaves the head there
  assign track_zero_input = (pos == 9'h000);
endmodule
`default_nettype wire

/* File: tb.sv */
// self-checking bench of the drive timing, configuration and seek engine
`default_nettype none
`include "fdtc_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock, rst_n, wr, rd, xfer_need, rw_request, rw_done;
  logic        set_pos, track_zero_input, step_out, dir_out;
  logic        head_load_out, rw_start, dma_request_out;
  logic        request_for_master, controller_interrupt, precomp_on;
  logic [8:0]  new_pos, pos;
  logic [7:0]  addr, rw_cylinder;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  fifo_burst;
  int          miscompares, n_checks;

  fdtc_top #(.UNIT_CYC_1M(4)) dut_u (.clock(clock), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .track_zero_input(track_zero_input), .step_out(step_out),
    .dir_out(dir_out), .head_load_out(head_load_out),
    .rw_request(rw_request), .rw_cylinder(rw_cylinder),
    .rw_start(rw_start), .rw_done(rw_done), .xfer_need(xfer_need),
    .dma_request_out(dma_request_out),
    .request_for_master(request_for_master),
    .controller_interrupt(controller_interrupt),
    .fifo_burst(fifo_burst), .precomp_on(precomp_on));
  fdtc_drive_model drv_u (.clock(clock), .rst_n(rst_n),
    .step_out(step_out), .dir_out(dir_out), .set_pos(set_pos),
    .new_pos(new_pos), .track_zero_input(track_zero_input), .pos(pos));

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic summarize();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_rng(string what, int lo, int hi, int got);
    n_checks++;
    if (got < lo || got > hi)
    begin
      miscompares++;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic timeout(string what);
    miscompares++;
    $display("[ERR] %s expected done seen timeout", what);
    summarize();
  endtask
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_chk(string what, logic [7:0] a, logic [31:0] m,
                        logic [31:0] e);
    rd_reg(a, rv);
    chk(what, e, rv & m);
  endtask
  task automatic do_reset();
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk("poll irq", 32'h1, {31'h0, controller_interrupt});
    rd_chk("poll st0", `FDTC_A_STATUS0, 32'hf0, 32'hc0);
    chk("irq clear", 32'h0, {31'h0, controller_interrupt});
  endtask
  // one motion command: counts and spaces steps up to the end interrupt
  task automatic run_motion(string what, logic [31:0] cmd, int n_exp,
                            int gap, logic [7:0] st0);
    int n, last, steps;
    n = 0;
    last = 0;
    steps = 0;
    wr_reg(`FDTC_A_MOTION, cmd);
    while (controller_interrupt !== 1'b1)
    begin
      @(posedge clock);
      #1 n++;
      if (n > 5000)
        timeout(what);
      if (step_out === 1'b1)
      begin
        if (steps == 0)
          chk_rng(what, 1, 2, n);
        else
          chk_rng(what, gap, gap, n - last);
        steps++;
        last = n;
      end
    end
    if (n_exp >= 0)
      chk(what, n_exp, steps);
    rd_chk(what, `FDTC_A_STATUS0, 32'hf0, {24'h0, st0});
  endtask
  task automatic rw_cycle(logic [7:0] cyl, int n_exp, bit load);
    int i, hl, steps;
    hl = -1;
    steps = 0;
    @(posedge clock);
    rw_request  <= 1'b1;
    rw_cylinder <= cyl;
    @(posedge clock);
    rw_request  <= 1'b0;
    // rw_start may already stand after this edge when the head is loaded
    #1;
    for (i = 0; rw_start !== 1'b1; i++)
    begin
      @(posedge clock);
      #1;
      if (i > 3000)
        timeout("rw start");
      if (step_out === 1'b1)
        steps++;
      if (head_load_out === 1'b1 && hl < 0)
        hl = i;
    end
    chk("rw steps", n_exp, steps);
    if (load)
      chk_rng("load delay", 16, 20, i - hl);
    else
      chk_rng("load skipped", 0, 6, i);
  endtask
  task automatic rw_end(bit wait_fall);
    int i;
    @(posedge clock);
    rw_done <= 1'b1;
    @(posedge clock);
    rw_done <= 1'b0;
    for (i = 0; wait_fall && head_load_out !== 1'b0; i++)
    begin
      @(posedge clock);
      #1;
      if (i > 3000)
        timeout("unload");
    end
    if (wait_fall)
      chk_rng("unload delay", 128, 133, i);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_defaults();
    logic [7:0]  a[6] = '{`FDTC_A_TIMING, `FDTC_A_CONFIG, `FDTC_A_RATE,
                          `FDTC_A_POSITION, `FDTC_A_VERSION, 8'h1c};
    logic [31:0] e[6] = '{32'h0, 32'h2, 32'h0, 32'h0, 32'h5a, 32'h0};
    wr_reg(8'h1c, 32'hffff_ffff);
    for (int i = 0; i < 6; i++)
      rd_chk("default", a[i], 32'hffff_ffff, e[i]);
    chk("burst", 32'h0, {28'h0, fifo_burst});
    chk("precomp", 32'h1, {31'h0, precomp_on});
  endtask
  task automatic t_modes();
    @(posedge clock);
    xfer_need <= 1'b1;
    @(posedge clock);
    #1 chk("dma", 32'h1, {request_for_master, dma_request_out});
    wr_reg(`FDTC_A_TIMING, 32'hffff);
    #1 chk("nodma", 32'h2, {request_for_master, dma_request_out});
    rd_chk("timing", `FDTC_A_TIMING, 32'hffff, 32'hffff);
    chk("pio irq", 32'h1, {31'h0, controller_interrupt});
    wr_reg(`FDTC_A_TIMING, 32'h7fff);
    #1 chk("dma", 32'h1, {request_for_master, dma_request_out});
    wr_reg(`FDTC_A_CONFIG, 32'h00f0);
    #1 chk("thr 16", 32'hf, {28'h0, fifo_burst});
    wr_reg(`FDTC_A_CONFIG, 32'h0000);
    #1 chk("thr 1", 32'h0, {28'h0, fifo_burst});
    wr_reg(`FDTC_A_CONFIG, 32'h00f2);
    #1 chk("fifo off", 32'h0, {28'h0, fifo_burst});
    @(posedge clock);
    xfer_need <= 1'b0;
    // the transfer interrupt must be gone before motion waits on it
    rd_reg(`FDTC_A_STATUS0, rv);
    chk("pio irq clr", 32'h0, {31'h0, controller_interrupt});
  endtask
  task automatic t_rates();
    logic [2:0] r[4] = '{fdtc_pkg::FDTC_R_2M, fdtc_pkg::FDTC_R_1M,
                         fdtc_pkg::FDTC_R_500K, fdtc_pkg::FDTC_R_250K};
    int         u[4] = '{2, 4, 8, 16};
    int         c[4] = '{15, 14, 0, 15};
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(`FDTC_A_RATE, {29'h0, r[i]});
      wr_reg(`FDTC_A_TIMING, c[i]);
      run_motion("gap in", 32'h303, 3, (16 - c[i]) * u[i] + 2, 8'h20);
      chk("head in", 32'h3, {23'h0, pos});
      run_motion("gap out", 32'h203, 3, (16 - c[i]) * u[i] + 2, 8'h20);
      rd_chk("cyl", `FDTC_A_POSITION, 32'hff, 32'h0);
    end
  endtask
  task automatic t_wrap();
    wr_reg(`FDTC_A_RATE, {29'h0, fdtc_pkg::FDTC_R_2M});
    wr_reg(`FDTC_A_TIMING, 32'hf);
    run_motion("rel 255", 32'h3ff, 255, 4, 8'h20);
    rd_chk("cyl 255", `FDTC_A_POSITION, 32'hff, 32'hff);
    run_motion("rel wrap", 32'h302, 2, 4, 8'h20);
    rd_chk("cyl wrap", `FDTC_A_POSITION, 32'hff, 32'h01);
    run_motion("recal far", 32'h400, 80, 4, 8'h70);
    rd_chk("cyl recal", `FDTC_A_POSITION, 32'hff, 32'h0);
    wr_reg(`FDTC_A_RATE, {29'h0, fdtc_pkg::FDTC_R_500K});
    @(posedge clock);
    set_pos <= 1'b1;
    new_pos <= 9'h005;
    @(posedge clock);
    set_pos <= 1'b0;
    run_motion("recal near", 32'h400, 5, 10, 8'h20);
    run_motion("rel past 0", 32'h202, 0, 10, 8'h70);
  endtask
  task automatic t_rw();
    wr_reg(`FDTC_A_TIMING, 32'h011f);
    wr_reg(`FDTC_A_CONFIG, 32'h0003);
    rw_cycle(8'h03, 3, 1'b1);
    rd_chk("cyl rw", `FDTC_A_POSITION, 32'hff, 32'h03);
    wr_reg(`FDTC_A_CONFIG, 32'h0303);
    #1 chk("precomp on", 32'h1, {31'h0, precomp_on});
    wr_reg(`FDTC_A_CONFIG, 32'h0403);
    #1 chk("precomp off", 32'h0, {31'h0, precomp_on});
    rw_end(1'b0);
    rw_cycle(8'h03, 0, 1'b0);
    rw_end(1'b1);
    wr_reg(`FDTC_A_CONFIG, 32'h0002);
    rw_cycle(8'h07, 0, 1'b1);
    rw_end(1'b1);
    rd_chk("no seek", `FDTC_A_POSITION, 32'hff, 32'h03);
    rd_chk("kept", `FDTC_A_TIMING, 32'hffff, 32'h011f);
  endtask

  initial
  begin
    {rst_n, wr, rd, xfer_need, rw_request, rw_done, set_pos} = 7'h00;
    {addr, rw_cylinder, new_pos} = 25'h0;
    wdata = 32'h0;
    miscompares = 0;
    n_checks = 0;
    do_reset();
    t_defaults();
    t_modes();
    t_rates();
    t_wrap();
    t_rw();
    do_reset();
    rd_chk("reset timing", `FDTC_A_TIMING, 32'hffff, 32'h0);
    rd_chk("reset cfg", `FDTC_A_CONFIG, 32'hffff, 32'h2);
    summarize();
  end
endmodule
`default_nettype wire
